// File: common/swsb_pkg.sv
// Constants and types shared by the single-wire sensor bridge
package swsb_pkg;
   // Clock and bus timing, times in ns
   localparam int CLK_NS        = 20;
   localparam int T_RST_LOW_NS  = 480000;
   localparam int T_RST_SMP_NS  = 70000;
   localparam int T_RST_REC_NS  = 410000;
   localparam int T_SLOT_NS     = 70000;
   localparam int T_W0_LOW_NS   = 60000;
   localparam int T_W1_LOW_NS   = 6000;
   localparam int T_RD_SMP_NS   = 15000;
   localparam int T_SEC_NS      = 1000000000;
   // Least times round up, sample points round down
   localparam int RST_LOW_CYC   = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_SMP_CYC   = RST_LOW_CYC + T_RST_SMP_NS / CLK_NS;
   localparam int RST_END_CYC   = RST_LOW_CYC + (T_RST_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLOT_CYC      = (T_SLOT_NS + CLK_NS - 1) / CLK_NS;
   localparam int W0_LOW_CYC    = (T_W0_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int W1_LOW_CYC    = T_W1_LOW_NS / CLK_NS;
   localparam int RD_SMP_CYC    = T_RD_SMP_NS / CLK_NS;
   localparam int SEC_CYC       = T_SEC_NS / CLK_NS;
   // Host packet codes
   localparam logic [7:0] CMD_DEV_INFO = 8'h12;
   localparam logic [7:0] CMD_TEMP_CFG = 8'h13;
   localparam logic [7:0] CMD_XACT     = 8'h14;
   localparam logic [7:0] RSP_FLAG     = 8'h40;
   localparam logic [7:0] RSP_ERR      = 8'hc0;
   localparam logic [7:0] RSP_TEMP     = 8'h82;
   // Bus command bytes
   localparam logic [7:0] BUS_SEARCH   = 8'hf0;
   localparam logic [7:0] BUS_MATCH    = 8'h55;
   localparam logic [7:0] BUS_SKIP     = 8'hcc;
   localparam logic [7:0] BUS_CONVERT  = 8'h44;
   localparam logic [7:0] BUS_RD_PAD   = 8'hbe;
   // Packet sizes and limits
   localparam int         CMD_BYTES    = 16;
   localparam int         SLOTS        = 16;
   localparam logic [7:0] SLOT_NONE    = 8'h10;
   localparam logic [7:0] MAX_RD       = 8'h0e;
   localparam logic [4:0] LEN_DEVINFO  = 5'h01;
   localparam logic [4:0] LEN_TEMPCFG  = 5'h04;
   localparam logic [4:0] LEN_XMIN     = 5'h02;
   localparam logic [4:0] LEN_XMAX     = 5'h10;
   localparam logic [4:0] RSP_DEVINFO  = 5'h09;
   localparam logic [4:0] RSP_TEMPLEN  = 5'h03;
   localparam logic [3:0] TEMP_RD      = 4'h2;
   localparam int         TXB          = 23;
   localparam int         RSP_W        = 9;
   localparam int         FIFO_DEPTH   = 8;

   typedef enum logic [1:0] {
      OP_RST = 2'b00,
      OP_W0  = 2'b01,
      OP_W1  = 2'b10,
      OP_RD  = 2'b11
   } swsb_op_t;

   typedef enum logic [1:0] {
      JOB_CMD  = 2'b00,
      JOB_TEMP = 2'b01,
      JOB_CONV = 2'b10
   } swsb_job_t;
endpackage

// File: common/swsb_stream_if.sv
// Valid/ready stream carrier between bridge modules
`timescale 1ns/10ps
`default_nettype none
interface swsb_stream_if #(parameter int W = 8) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hdl/swsb_fifo.sv
// Parameterised response FIFO
`timescale 1ns/10ps
`default_nettype none
module swsb_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic     mclk,
   input wire logic     rst,
   // Fill and drain sides
   swsb_stream_if.snk   wr,
   swsb_stream_if.src   rd
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam logic [AW-1:0] LAST = AW'(D - 1);
   localparam logic [AW:0]   FULL = (AW+1)'(D);

   logic [W-1:0]  mem_r [0:D-1];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign wr.ready = (cnt_r != FULL);
   assign rd.valid = (cnt_r != '0);
   assign rd.data  = mem_r[rp_r];
   assign push     = wr.valid & wr.ready;
   assign pop      = rd.valid & rd.ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_r[wp_r] <= wr.data;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == LAST) ? '0 : AW'(wp_r + 1'b1);
         end
         if (pop) begin
            rp_r <= (rp_r == LAST) ? '0 : AW'(rp_r + 1'b1);
         end
         if (push && !pop) begin
            cnt_r <= (AW+1)'(cnt_r + 1'b1);
         end else if (pop && !push) begin
            cnt_r <= (AW+1)'(cnt_r - 1'b1);
         end
      end
   end
endmodule
`default_nettype wire

// File: hdl/swsb_bridge.sv
// Host packet to single-wire sensor bus bridge
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - After reset, search the bus and store up to 16 found identity records.
// - Device-info command 0x12 has one byte, a slot index 0 to 15.
// - Device-info answer is 0x52 with nine bytes: slot, then identity record.
// - First returned record byte is the family code.
// - Only slots of the two sensor families may do timed conversion.
// - Report setup 0x13 has four bytes: slot enable masks, two zeros; ack 0x53.
// - Each enabled sensor slot is reported to the host once per second.
// - A transaction writes at most 14 payload bytes and reads at most 14.
// - Transaction is bus reset, address phase, then write and/or read.
// - Transaction command 0x14: 2-16 bytes, slot 0-16, read count 0-14, payload.
// - Slot 16 means no address phase.
// - Found slot gets select-by-serial plus its identity record before the write.
// - Two data bytes means no write phase beyond any address bytes.
// - More bytes: payload of length minus two follows the address phase.
// - Zero read count skips reading, else read bytes go into the answer.
module swsb_bridge #(
   parameter int         RST_LOW    = swsb_pkg::RST_LOW_CYC,
   parameter int         RST_SMP    = swsb_pkg::RST_SMP_CYC,
   parameter int         RST_END    = swsb_pkg::RST_END_CYC,
   parameter int         SEC_CYCLES = swsb_pkg::SEC_CYC,
   parameter int         DEPTH      = swsb_pkg::FIFO_DEPTH,
   parameter logic [7:0] FAM_A      = 8'h3a,  // Arbitrary value
   parameter logic [7:0] FAM_B      = 8'h5c   // Arbitrary value
) (
   // Clock and reset
   input  wire logic                              mclk,
   input  wire logic                              rst,
   // Host command packet
   input  wire logic                              cmd_valid,
   output logic                                   cmd_ready,
   input  wire logic [7:0]                        cmd_type,
   input  wire logic [4:0]                        cmd_len,
   input  wire logic [swsb_pkg::CMD_BYTES*8-1:0]  cmd_data,
   // Response byte stream
   output logic                                   rsp_valid,
   input  wire logic                              rsp_ready,
   output logic [7:0]                             rsp_data,
   output logic                                   rsp_last,
   // Single-wire bus pin
   input  wire logic                              dq_i,
   output logic                                   dq_o,
   output logic                                   dq_oe,
   // Status
   output logic                                   enum_done
);
   import swsb_pkg::*;

   typedef enum logic [4:0] {
      S_BOOT  = 5'h00, S_E_RST = 5'h01, S_E_CMD = 5'h02, S_E_RB  = 5'h03,
      S_E_RC  = 5'h04, S_E_WD  = 5'h05, S_E_STO = 5'h06, S_IDLE  = 5'h07,
      S_T_NXT = 5'h08, S_X_RST = 5'h09, S_X_WR  = 5'h0a, S_X_RD  = 5'h0b,
      S_RESP  = 5'h0c
   } swsb_st_t;

   swsb_stream_if #(.W(RSP_W)) push_if ();
   swsb_stream_if #(.W(RSP_W)) pop_if ();

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and bit-slot engine
   logic           dq_s1_r, dq_s2_r, dq_s3_r, dq_f_r;
   swsb_op_t       op_r, kind_r;
   logic           op_go_r, busy_r, bit_done_r, bit_val_r;
   logic [15:0]    cnt_r, low_lim, smp_lim, end_lim;

   assign dq_o = 1'b0;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dq_s1_r <= 1'b1;
         dq_s2_r <= 1'b1;
         dq_s3_r <= 1'b1;
         dq_f_r  <= 1'b1;
      end else begin
         dq_s1_r <= dq_i;
         dq_s2_r <= dq_s1_r;
         dq_s3_r <= dq_s2_r;
         if (dq_s2_r == dq_s3_r) begin
            dq_f_r <= dq_s3_r;
         end
      end
   end

   always_comb begin
      case (kind_r)
         OP_RST: begin
            low_lim = 16'(RST_LOW);
            smp_lim = 16'(RST_SMP);
            end_lim = 16'(RST_END);
         end
         OP_W0: begin
            low_lim = 16'(W0_LOW_CYC);
            smp_lim = 16'(RD_SMP_CYC);
            end_lim = 16'(SLOT_CYC);
         end
         default: begin
            low_lim = 16'(W1_LOW_CYC);
            smp_lim = 16'(RD_SMP_CYC);
            end_lim = 16'(SLOT_CYC);
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         kind_r     <= OP_RST;
         busy_r     <= 1'b0;
         bit_done_r <= 1'b0;
         bit_val_r  <= 1'b1;
         cnt_r      <= '0;
         dq_oe      <= 1'b0;
      end else begin
         bit_done_r <= 1'b0;
         if (op_go_r) begin
            kind_r <= op_r;
            busy_r <= 1'b1;
            cnt_r  <= '0;
            dq_oe  <= 1'b1;
         end else if (busy_r) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == low_lim - 16'h0001) begin
               dq_oe <= 1'b0;
            end
            if (cnt_r == smp_lim) begin
               bit_val_r <= dq_f_r;
            end
            if (cnt_r == end_lim - 16'h0001) begin
               busy_r     <= 1'b0;
               bit_done_r <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Once-per-second tick and sensor eligibility
   logic [31:0]      sec_cnt_r;
   logic             sec_tick;
   logic [SLOTS-1:0] found_r, elig, temp_en_r;
   logic [63:0]      id_mem_r [0:SLOTS-1];

   assign sec_tick = (sec_cnt_r == 32'(SEC_CYCLES - 1));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sec_cnt_r <= '0;
      end else begin
         sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 32'h1;
      end
   end

   for (genvar g = 0; g < SLOTS; g++) begin : g_elig
      assign elig[g] = found_r[g] &&
                       (id_mem_r[g][7:0] == FAM_A || id_mem_r[g][7:0] == FAM_B);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode helpers
   logic [7:0]       d0, d1;
   logic [4:0]       x_off, x_len;
   logic [TXB*8-1:0] x_pfx, x_tx;
   logic             x_ok;

   assign d0 = cmd_data[7:0];
   assign d1 = cmd_data[15:8];
   assign x_ok = cmd_len >= LEN_XMIN && cmd_len <= LEN_XMAX && d0 <= SLOT_NONE &&
                 d1 <= MAX_RD && (cmd_len != LEN_XMIN || d1 != 8'h00);

   always_comb begin
      x_pfx = '0;
      if (d0 == SLOT_NONE) begin
         x_off = 5'd0;
      end else if (d0 < SLOT_NONE && found_r[d0[3:0]]) begin
         x_off = 5'd9;
         x_pfx[71:0] = {id_mem_r[d0[3:0]], BUS_MATCH};
      end else begin
         x_off = 5'd1;
         x_pfx[7:0] = BUS_SKIP;
      end
      // Payload sits straight after the address bytes
      x_tx  = ({72'h0, cmd_data[127:16]} << {x_off, 3'b000}) | x_pfx;
      x_len = 5'(x_off + cmd_len - LEN_XMIN);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequencer
   swsb_st_t         st_r;
   swsb_job_t        job_r;
   logic             pend_r, b_r, temp_pend_r, rx_base_r, dir, push_last;
   logic [3:0]       slot_r, rd_cnt_r, ri_r;
   logic [4:0]       tslot_r, tx_len_r, wi_r, rsp_len_r, ridx_r;
   logic [5:0]       idb_r;
   logic [6:0]       ld_r, lz_r, bitnum;
   logic [2:0]       bitn_r;
   logic [63:0]      rom_r;
   logic [7:0]       sh_r, rsp_type_r, push_byte;
   logic [TXB*8-1:0] tx_r;
   logic [7:0]       rsp_buf_r [0:15];

   // Commands wait until the enumeration flag is already up
   assign cmd_ready = (st_r == S_IDLE) && enum_done && !temp_pend_r;
   assign bitnum    = {1'b0, idb_r} + 7'd1;

   always_comb begin
      if (b_r != bit_val_r) begin
         dir = b_r;
      end else if (bitnum < ld_r) begin
         dir = rom_r[idb_r];
      end else begin
         dir = (bitnum == ld_r);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= S_BOOT;  job_r <= JOB_CMD;  pend_r <= 1'b0;  op_go_r <= 1'b0;
         op_r <= OP_RST;  b_r <= 1'b0;  temp_pend_r <= 1'b0;  rx_base_r <= 1'b0;
         slot_r <= '0;  rd_cnt_r <= '0;  ri_r <= '0;  tslot_r <= '0;  tx_len_r <= '0;
         wi_r <= '0;  rsp_len_r <= '0;  ridx_r <= '0;  idb_r <= '0;  ld_r <= '0;
         lz_r <= '0;  bitn_r <= '0;  rom_r <= '0;  sh_r <= '0;  rsp_type_r <= '0;
         tx_r <= '0;  found_r <= '0;  temp_en_r <= '0;  enum_done <= 1'b0;
         for (int i = 0; i < SLOTS; i++) begin
            id_mem_r[i]  <= '0;
            rsp_buf_r[i] <= '0;
         end
      end else begin
         op_go_r <= 1'b0;
         case (st_r)
            S_BOOT: begin
               tx_r[7:0] <= BUS_SEARCH;
               st_r      <= S_E_RST;
            end
            S_E_RST: begin
               if (!pend_r) begin
                  op_r <= OP_RST;  op_go_r <= 1'b1;  pend_r <= 1'b1;
               end else if (bit_done_r) begin
                  pend_r <= 1'b0;  bitn_r <= '0;
                  st_r   <= bit_val_r ? S_IDLE : S_E_CMD;
               end
            end
            S_E_CMD: begin
               if (!pend_r) begin
                  op_r <= tx_r[bitn_r] ? OP_W1 : OP_W0;  op_go_r <= 1'b1;  pend_r <= 1'b1;
               end else if (bit_done_r) begin
                  pend_r <= 1'b0;  bitn_r <= bitn_r + 3'd1;
                  if (bitn_r == 3'd7) begin
                     idb_r <= '0;  lz_r <= '0;  st_r <= S_E_RB;
                  end
               end
            end
            S_E_RB, S_E_RC: begin
               if (!pend_r) begin
                  op_r <= OP_RD;  op_go_r <= 1'b1;  pend_r <= 1'b1;
               end else if (bit_done_r) begin
                  pend_r <= 1'b0;
                  if (st_r == S_E_RB) begin
                     b_r <= bit_val_r;  st_r <= S_E_RC;
                  end else if (b_r && bit_val_r) begin
                     st_r <= S_IDLE;
                  end else begin
                     if (!b_r && !bit_val_r && !dir) begin
                        lz_r <= bitnum;
                     end
                     rom_r[idb_r] <= dir;  st_r <= S_E_WD;
                  end
               end
            end
            S_E_WD: begin
               if (!pend_r) begin
                  op_r <= rom_r[idb_r] ? OP_W1 : OP_W0;  op_go_r <= 1'b1;  pend_r <= 1'b1;
               end else if (bit_done_r) begin
                  pend_r <= 1'b0;  idb_r <= idb_r + 6'd1;
                  st_r   <= (idb_r == 6'd63) ? S_E_STO : S_E_RB;
               end
            end
            S_E_STO: begin
               id_mem_r[slot_r] <= rom_r;
               found_r[slot_r]  <= 1'b1;
               ld_r   <= lz_r;  slot_r <= slot_r + 4'd1;
               st_r   <= (lz_r == 7'd0 || slot_r == 4'd15) ? S_IDLE : S_E_RST;
            end
            S_IDLE: begin
               enum_done <= 1'b1;
               job_r     <= JOB_CMD;
               ridx_r    <= '0;
               rx_base_r <= 1'b0;
               if (cmd_valid && cmd_ready) begin
                  rsp_type_r <= cmd_type | RSP_ERR;
                  rsp_len_r  <= '0;
                  st_r       <= S_RESP;
                  case (cmd_type)
                     CMD_DEV_INFO: begin
                        if (cmd_len == LEN_DEVINFO && d0 < SLOT_NONE) begin
                           rsp_type_r   <= cmd_type | RSP_FLAG;
                           rsp_len_r    <= RSP_DEVINFO;
                           rsp_buf_r[0] <= d0;
                           for (int k = 0; k < 8; k++) begin
                              rsp_buf_r[k+1] <= id_mem_r[d0[3:0]][8*k +: 8];
                           end
                        end
                     end
                     CMD_TEMP_CFG: begin
                        if (cmd_len == LEN_TEMPCFG && cmd_data[31:16] == 16'h0000) begin
                           temp_en_r  <= {d1, d0};
                           rsp_type_r <= cmd_type | RSP_FLAG;
                        end
                     end
                     CMD_XACT: begin
                        if (x_ok) begin
                           rsp_type_r <= cmd_type | RSP_FLAG;
                           rsp_len_r  <= d1[4:0];
                           rd_cnt_r   <= d1[3:0];
                           tx_r       <= x_tx;
                           tx_len_r   <= x_len;
                           st_r       <= S_X_RST;
                        end
                     end
                     default: begin
                     end
                  endcase
               end else if (temp_pend_r) begin
                  temp_pend_r <= 1'b0;  tslot_r <= '0;  st_r <= S_T_NXT;
               end
            end
            S_T_NXT: begin
               rsp_buf_r[0] <= {3'b000, tslot_r};
               rsp_type_r   <= RSP_TEMP;
               rsp_len_r    <= RSP_TEMPLEN;
               rx_base_r    <= 1'b1;
               ridx_r       <= '0;
               tx_r         <= '0;
               if (tslot_r == 5'd16) begin
                  // Start the next conversion on every sensor at once
                  tx_r[15:0] <= {BUS_CONVERT, BUS_SKIP};
                  tx_len_r   <= 5'd2;  rd_cnt_r <= '0;  job_r <= JOB_CONV;
                  st_r       <= S_X_RST;
               end else if (elig[tslot_r[3:0]] && temp_en_r[tslot_r[3:0]]) begin
                  tx_r[79:0] <= {BUS_RD_PAD, id_mem_r[tslot_r[3:0]], BUS_MATCH};
                  tx_len_r   <= 5'd10;  rd_cnt_r <= TEMP_RD;  job_r <= JOB_TEMP;
                  st_r       <= S_X_RST;
               end else begin
                  tslot_r <= tslot_r + 5'd1;
               end
            end
            S_X_RST: begin
               if (!pend_r) begin
                  op_r <= OP_RST;  op_go_r <= 1'b1;  pend_r <= 1'b1;
               end else if (bit_done_r) begin
                  pend_r <= 1'b0;  wi_r <= '0;  ri_r <= '0;  bitn_r <= '0;
                  st_r   <= (tx_len_r == 5'd0) ? S_X_RD : S_X_WR;
               end
            end
            S_X_WR: begin
               if (!pend_r) begin
                  op_r    <= tx_r[{wi_r, bitn_r}] ? OP_W1 : OP_W0;
                  op_go_r <= 1'b1;  pend_r <= 1'b1;
               end else if (bit_done_r) begin
                  pend_r <= 1'b0;  bitn_r <= bitn_r + 3'd1;
                  if (bitn_r == 3'd7) begin
                     wi_r <= wi_r + 5'd1;
                     if (wi_r == tx_len_r - 5'd1) begin
                        st_r <= S_X_RD;
                     end
                  end
               end
            end
            S_X_RD: begin
               if (ri_r == rd_cnt_r) begin
                  st_r <= (job_r == JOB_CONV) ? S_IDLE : S_RESP;
               end else if (!pend_r) begin
                  op_r <= OP_RD;  op_go_r <= 1'b1;  pend_r <= 1'b1;
               end else if (bit_done_r) begin
                  pend_r <= 1'b0;  bitn_r <= bitn_r + 3'd1;
                  sh_r   <= {bit_val_r, sh_r[7:1]};
                  if (bitn_r == 3'd7) begin
                     rsp_buf_r[4'(ri_r + {3'b000, rx_base_r})] <= {bit_val_r, sh_r[7:1]};
                     ri_r <= ri_r + 4'd1;
                  end
               end
            end
            S_RESP: begin
               if (push_if.ready) begin
                  ridx_r <= ridx_r + 5'd1;
                  if (push_last) begin
                     tslot_r <= tslot_r + 5'd1;
                     st_r    <= (job_r == JOB_TEMP) ? S_T_NXT : S_IDLE;
                  end
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
         // A tick arriving with the clear still leaves a scan pending
         if (sec_tick && |(elig & temp_en_r)) begin
            temp_pend_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response packets: type, length, data bytes
   always_comb begin
      case (ridx_r)
         5'd0:    push_byte = rsp_type_r;
         5'd1:    push_byte = {3'b000, rsp_len_r};
         default: push_byte = rsp_buf_r[4'(ridx_r - 5'd2)];
      endcase
   end

   assign push_last     = (ridx_r == rsp_len_r + 5'd1);
   assign push_if.valid = (st_r == S_RESP);
   assign push_if.data  = {push_last, push_byte};
   assign rsp_valid     = pop_if.valid;
   assign rsp_data      = pop_if.data[7:0];
   assign rsp_last      = pop_if.data[8];
   assign pop_if.ready  = rsp_ready;

   swsb_fifo #(.W(RSP_W), .D(DEPTH)) u_fifo (
      .mclk (mclk),
      .rst  (rst),
      .wr   (push_if),
      .rd   (pop_if)
   );
endmodule
`default_nettype wire

// File: verif/swsb_bridge_props.sv
// Port assertions for the bridge
`timescale 1ns/10ps
`default_nettype none
module swsb_bridge_props (
   // Clock, reset and host side
   input wire logic         mclk,
   input wire logic         rst,
   input wire logic         cmd_valid,
   input wire logic         cmd_ready,
   input wire logic [7:0]   cmd_type,
   input wire logic [4:0]   cmd_len,
   input wire logic [127:0] cmd_data,
   input wire logic         rsp_valid,
   input wire logic         rsp_ready,
   input wire logic [7:0]   rsp_data,
   // Bus and status
   input wire logic         dq_oe,
   input wire logic         enum_done
);
   import swsb_pkg::*;
   logic take;
   assign take = cmd_valid && cmd_ready && !rsp_valid;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_enum_stays: assert property (enum_done |=> enum_done) else $error("enum fell");
   a_ready_enum: assert property (cmd_ready |-> enum_done) else $error("early ready");
   a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("stalled byte changed");
   a_info_type: assert property (take && cmd_type == CMD_DEV_INFO && cmd_len == 5'h01 &&
      cmd_data[7:0] < 8'h10 |-> ##2 rsp_valid && rsp_data == 8'h52) else $error("info");
   a_info_bad: assert property (take && cmd_type == CMD_DEV_INFO && cmd_data[7:0] > 8'h0f
      |-> ##2 rsp_data == 8'hd2) else $error("bad index taken");
   a_cfg_ack: assert property (take && cmd_type == CMD_TEMP_CFG && cmd_len == 5'h04 &&
      cmd_data[31:16] == 16'h0 |-> ##2 rsp_valid && rsp_data == 8'h53) else $error("ack");
   a_bus_idle: assert property (cmd_ready |-> !dq_oe) else $error("bus driven idle");
   a_low_min: assert property ($rose(dq_oe) |-> dq_oe[*8]) else $error("short low");
endmodule
bind swsb_bridge swsb_bridge_props i_props (.mclk, .rst, .cmd_valid, .cmd_ready, .cmd_type,
   .cmd_len, .cmd_data, .rsp_valid, .rsp_ready, .rsp_data, .dq_oe, .enum_done);
`default_nettype wire

// File: verif/swsb_bus_model.sv
// Single-wire bus device: logs written bits, answers read slots
`timescale 1ns/10ps
`default_nettype none
module swsb_bus_model (
   // Clock and bus level
   input wire logic       mclk,
   input wire logic       dq,
   // Behaviour
   input wire logic       present,
   input wire logic [7:0] tx_byte,
   input wire logic [7:0] tx_from,
   // Pull-down and observed traffic
   output logic           pull,
   output logic [7:0]     rx_byte,
   output logic [7:0]     bit_cnt = 8'h00
);
   int         lo = 0;
   int         t = 99999;
   int         pt = 99999;
   logic       dq_d = 1'b1;
   logic [7:0] k;
   assign k = bit_cnt - tx_from;
   // Presence after reset, zero bits held past the sample point
   // Released before the bit counter steps, so no second fall in one slot
   assign pull = (present && pt > 100 && pt < 1500) || (pt > 3000 && bit_cnt >= tx_from &&
                 k < 8'h08 && t < 1000 && !tx_byte[k[2:0]]);
   always @(posedge mclk) begin
      dq_d <= dq;
      lo <= dq ? 0 : lo + 1;
      t <= (dq_d && !dq) ? 0 : t + 1;
      pt <= (!dq_d && dq && lo > 3500) ? 0 : pt + 1;
      if (!dq_d && dq && lo > 3500) begin
         bit_cnt <= 8'h00;
      end else if (t == 1000 && pt > 3000) begin
         bit_cnt <= bit_cnt + 8'h01;
         if (bit_cnt < tx_from)
            rx_byte <= {dq, rx_byte[7:1]};
      end
   end
endmodule
`default_nettype wire

// File: verif/test_swsb_bridge.sv
// Self-checking bench for the bridge
`timescale 1ns/10ps
`default_nettype none
module test_swsb_bridge;
   import swsb_pkg::*;
   logic         mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, rsp_ready = 1'b1, present = 1'b0;
   logic [7:0]   cmd_type = 8'h00, rsp_data, rx_byte, bit_cnt, b;
   logic [4:0]   cmd_len = 5'h00;
   logic [127:0] cmd_data = '0;
   logic         cmd_ready, rsp_valid, rsp_last, dq_oe, enum_done, pull, l;
   wire logic    dq;
   int           err_count = 0, num_checks = 0, cyc = 0;
   assign dq = !(dq_oe || pull);
   always #10 mclk = !mclk;
   swsb_bridge #(.RST_LOW(4000), .RST_SMP(4500), .RST_END(8000)) i_dut (.mclk, .rst, .cmd_valid,
      .cmd_ready, .cmd_type, .cmd_len, .cmd_data, .rsp_valid, .rsp_ready, .rsp_data, .rsp_last,
      .dq_i(dq), .dq_o(), .dq_oe, .enum_done);
   swsb_bus_model i_dev (.mclk, .dq, .present, .tx_byte(8'h3c), .tx_from(8'h08), .pull,
      .rx_byte, .bit_cnt);
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic send(input logic [7:0] t, input logic [4:0] n, input logic [127:0] d);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_type <= t;
      cmd_len <= n;
      cmd_data <= d;
      do @(negedge mclk); while (cmd_ready !== 1'b1);
      @(posedge mclk);
      cmd_valid <= 1'b0;
   endtask
   task automatic get();
      do @(negedge mclk); while (rsp_valid !== 1'b1);
      b = rsp_data;
      l = rsp_last;
      @(posedge mclk);
   endtask
   task automatic pkt(input logic [7:0] t, input logic [7:0] n);
      get();
      chk("type", t, b);
      get();
      chk("length", n, b);
      chk("last", {7'h0, n == 8'h00}, {7'h0, l});
   endtask
   task automatic t_refuse();
      logic [7:0]  ty [7] = '{8'h12, 8'h12, 8'h13, 8'h14, 8'h14, 8'h14, 8'h7e};
      logic [4:0]  ln [7] = '{5'h01, 5'h02, 5'h04, 5'h02, 5'h02, 5'h03, 5'h00};
      logic [23:0] dt [7] = '{24'h10, 24'h03, 24'h010000, 24'h0f10, 24'h10, 24'h11, 24'h0};
      for (int i = 0; i < 7; i++) begin
         send(ty[i], ln[i], {104'h0, dt[i]});
         pkt(ty[i] | RSP_ERR, 8'h00);
      end
   endtask
   task automatic t_info();
      rsp_ready <= 1'b0;
      send(CMD_DEV_INFO, 5'h01, 128'h0f);
      repeat (40) @(posedge mclk);
      chk("stalled valid", 8'h01, {7'h0, rsp_valid});
      rsp_ready <= 1'b1;
      pkt(8'h52, 8'h09);
      for (int i = 0; i < 9; i++) begin
         get();
         if (i == 0)
            chk("slot", 8'h0f, b);
         chk("last", {7'h0, i == 8}, {7'h0, l});
      end
   endtask
   task automatic t_cfg();
      send(CMD_TEMP_CFG, 5'h04, 128'h0);
      pkt(8'h53, 8'h00);
   endtask
   task automatic t_xact();
      present <= 1'b1;
      send(CMD_XACT, 5'h03, 128'ha50110);
      pkt(8'h54, 8'h01);
      get();
      chk("read byte", 8'h3c, b);
      chk("read last", 8'h01, {7'h0, l});
      chk("written byte", 8'ha5, rx_byte);
      chk("bus bits", 8'h10, bit_cnt);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_refuse();
      t_info();
      t_cfg();
      t_xact();
      print_verdict();
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 100000) begin
         err_count++;
         $display("ERROR cycles expected below %0d seen %0d", 100000, cyc);
         print_verdict();
      end
   end
endmodule
`default_nettype wire
